// *** rtl/rpf_framer.v ***
/*
  Radio packet framer: builds frames from the transmit FIFO onto a
  serial bit stream and takes received bit streams apart into the
  receive FIFO. Assumes same-clock modem and FIFO logic, received
  bits spaced at least two clocks apart, and a host that drives
  all configuration ports as levels.
*/
`include "rpf_regs.vh"
module rpf_framer #(
  parameter PRE_W = 4
) (
  input wire clk_in,
  input wire srst_in,
  input wire tx_start_in,
  input wire rx_start_in,
  input wire stop_in,
  input wire [1:0] preamble_sel_in,
  input wire [PRE_W-1:0] preamble_min_in,
  input wire [31:0] sync_word_bytes_in,
  input wire [2:0] sync_len_in,
  input wire crc_en_in,
  input wire append_status_en_in,
  input wire whitening_en_in,
  input wire [1:0] addr_check_in,
  input wire [7:0] node_address_in,
  input wire [1:0] length_cfg_in,
  input wire [7:0] packet_length_reg_in,
  input wire [2:0] tail_bit_count_in,
  input wire [1:0] tx_exit_state_in,
  input wire [1:0] rx_exit_state_in,
  input wire [7:0] rssi_in,
  input wire [6:0] link_quality_value_in,
  input wire txf_valid_in,
  input wire [7:0] txf_data_in,
  output wire txf_ready_out,
  output wire tx_bit_out,
  output wire tx_bit_valid_out,
  input wire tx_bit_ready_in,
  input wire rx_bit_in,
  input wire rx_bit_valid_in,
  output wire rxf_valid_out,
  output wire [7:0] rxf_data_out,
  output wire busy_out,
  output wire exit_valid_out,
  output wire [1:0] exit_state_out,
  output wire discard_out,
  output wire crc_ok_out
);
  localparam IDLE = 3'h0;
  localparam PRE = 3'h1;
  localparam SYNC = 3'h2;
  localparam DATA = 3'h3;
  localparam CRC = 3'h4;
  localparam STAT = 3'h5;

  reg [2:0] st_r;
  reg rx_r;
  reg [31:0] sh_r;
  reg [5:0] bc_r;
  reg [7:0] cnt_r;
  reg [7:0] vlen_r;
  reg [PRE_W-1:0] pc_r;
  reg [15:0] crc_r;
  reg [8:0] pn_r;
  reg [31:0] win_r;
  reg hdr_r;
  reg adr_r;
  reg tail_r;
  reg any_r;
  reg ok_r;
  reg rxf_valid_r;
  reg [7:0] rxf_data_r;
  reg exit_valid_r;
  reg [1:0] exit_state_r;
  reg discard_r;

  // CRC over one byte, MSB first
  function [15:0] crc8f;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] x;
    begin
      x = c;
      for (i = 7; i >= 0; i = i - 1) begin
        x = {x[14:0], 1'b0} ^ ((x[15] ^ d[i]) ? `RPF_CRC_POLY : 16'h0000);
      end
      crc8f = x;
    end
  endfunction

  // Advance whitening sequence by one byte
  function [8:0] pn8f;
    input [8:0] p;
    integer i;
    reg [8:0] x;
    begin
      x = p;
      for (i = 0; i < 8; i = i + 1) begin
        x = {x[5] ^ x[0], x[8:1]};
      end
      pn8f = x;
    end
  endfunction

  function [5:0] slenf;
    input [2:0] s;
    begin
      case (s)
        `RPF_SYNC_11: slenf = `RPF_BITS_11;
        `RPF_SYNC_16: slenf = `RPF_BITS_16;
        `RPF_SYNC_18: slenf = `RPF_BITS_18;
        `RPF_SYNC_24: slenf = `RPF_BITS_24;
        default: slenf = `RPF_BITS_32;
      endcase
    end
  endfunction

  wire fixm = length_cfg_in == `RPF_LEN_FIXED;
  wire var5 = length_cfg_in == `RPF_LEN_VAR5;
  wire varm = length_cfg_in == `RPF_LEN_VAR || var5;
  wire [2:0] m = tail_bit_count_in;
  wire mt = fixm && m != 3'h0;
  wire [7:0] tgt = fixm ? packet_length_reg_in : vlen_r;
  // Infinite mode never hits; settings read live each byte
  wire hit = (fixm || varm) && !hdr_r && cnt_r == tgt && (any_r || varm || mt);
  wire tail_go = hit && mt && !tail_r;
  wire done = hit && !tail_go;
  wire crc_on = crc_en_in && !mt;
  wire [5:0] sl = slenf(sync_len_in);
  wire [5:0] sgap = 6'h20 - sl;
  wire [31:0] smask = 32'hFFFFFFFF >> sgap;
  wire [31:0] win_nxt = {win_r[30:0], rx_bit_in};
  wire rbit = rx_r && rx_bit_valid_in;
  wire [8:0] pnn = pn8f(pn_r);
  wire [7:0] wb = whitening_en_in ? pn_r[7:0] : 8'h00;
  wire [15:0] cw = whitening_en_in ? {pn_r[7:0], pnn[7:0]} : 16'h0000;
  wire [2:0] sft = 3'h0 - m;
  wire [7:0] raw = {sh_r[6:0], rx_bit_in};
  wire [7:0] rawt = tail_r ? raw << sft : raw;
  wire [7:0] tmask = tail_r ? 8'hFF << sft : 8'hFF;
  wire [7:0] db = (rawt ^ wb) & tmask;
  wire [7:0] lb = var5 ? db & `RPF_LEN5_MASK : db;
  wire [7:0] tb = txf_data_in;
  wire [7:0] tlb = var5 ? tb & `RPF_LEN5_MASK : tb;
  wire amatch = db == node_address_in || (addr_check_in[1] && db == `RPF_BCAST_LO) ||
    (addr_check_in == `RPF_ADDR_BC0FF && db == `RPF_BCAST_HI);
  reg [7:0] pat;

  always @* begin
    case (preamble_sel_in)
      2'h0: pat = `RPF_PRE_1010;
      2'h1: pat = `RPF_PRE_0101;
      2'h2: pat = `RPF_PRE_0011;
      default: pat = `RPF_PRE_1100;
    endcase
  end

  assign txf_ready_out = !rx_r && st_r == DATA && bc_r == 6'h00 && !done && txf_valid_in;
  assign tx_bit_out = sh_r[31];
  assign tx_bit_valid_out = !rx_r && bc_r != 6'h00 && st_r != IDLE && st_r != STAT;
  assign rxf_valid_out = rxf_valid_r;
  assign rxf_data_out = rxf_data_r;
  assign busy_out = st_r != IDLE;
  assign exit_valid_out = exit_valid_r;
  assign exit_state_out = exit_state_r;
  assign discard_out = discard_r;
  assign crc_ok_out = ok_r;

  task start_data;
    begin
      st_r <= DATA;
      bc_r <= 6'h00;
      cnt_r <= 8'h00;
      any_r <= 1'b0;
      tail_r <= 1'b0;
      hdr_r <= varm;
      adr_r <= addr_check_in != 2'h0;
      crc_r <= `RPF_CRC_INIT;
      pn_r <= `RPF_PN9_INIT;
      ok_r <= 1'b1;
    end
  endtask

  task end_pkt;
    begin
      st_r <= IDLE;
      exit_valid_r <= 1'b1;
      exit_state_r <= rx_r ? rx_exit_state_in : tx_exit_state_in;
    end
  endtask

  task end_rx;
    begin
      if (append_status_en_in) begin
        st_r <= STAT;
        bc_r <= `RPF_STAT_BYTES;
      end else begin
        end_pkt;
      end
    end
  endtask

  task drop;
    begin
      st_r <= SYNC;
      win_r <= 32'h00000000;
      discard_r <= 1'b1;
    end
  endtask

  task tx_shift;
    begin
      if (tx_bit_ready_in) begin
        sh_r <= {sh_r[30:0], 1'b0};
        bc_r <= bc_r - 6'h01;
      end
    end
  endtask

  always @(posedge clk_in) begin
    exit_valid_r <= 1'b0;
    rxf_valid_r <= 1'b0;
    discard_r <= 1'b0;
    if (srst_in) begin
      st_r <= IDLE;
      rx_r <= 1'b0;
      sh_r <= 32'h00000000;
      bc_r <= 6'h00;
      cnt_r <= 8'h00;
      vlen_r <= 8'h00;
      pc_r <= {PRE_W{1'b0}};
      crc_r <= `RPF_CRC_INIT;
      pn_r <= `RPF_PN9_INIT;
      win_r <= 32'h00000000;
      hdr_r <= 1'b0;
      adr_r <= 1'b0;
      tail_r <= 1'b0;
      any_r <= 1'b0;
      ok_r <= 1'b1;
      rxf_data_r <= 8'h00;
      exit_state_r <= 2'h0;
    end else if (stop_in) begin
      st_r <= IDLE;
      bc_r <= 6'h00;
    end else begin
      case (st_r)
        IDLE: begin
          if (tx_start_in) begin
            rx_r <= 1'b0;
            st_r <= PRE;
            pc_r <= {PRE_W{1'b0}};
            bc_r <= 6'h00;
            ok_r <= 1'b1;
          end else if (rx_start_in) begin
            rx_r <= 1'b1;
            st_r <= SYNC;
            win_r <= 32'h00000000;
          end
        end
        PRE: begin
          if (bc_r == 6'h00) begin
            if (pc_r >= preamble_min_in && txf_valid_in) begin
              st_r <= SYNC;
              sh_r <= sync_word_bytes_in << sgap;
              bc_r <= sl;
            end else begin
              sh_r <= {pat, 24'h000000};
              bc_r <= `RPF_BYTE_BITS;
              if (pc_r != {PRE_W{1'b1}}) begin
                pc_r <= pc_r + {{(PRE_W-1){1'b0}}, 1'b1};
              end
            end
          end else begin
            tx_shift;
          end
        end
        SYNC: begin
          if (rx_r) begin
            if (rbit) begin
              win_r <= win_nxt;
              if ((win_nxt & smask) == (sync_word_bytes_in & smask)) begin
                start_data;
              end
            end
          end else if (bc_r == 6'h00) begin
            start_data;
          end else begin
            tx_shift;
          end
        end
        DATA: begin
          if (bc_r == 6'h00) begin
            if (done) begin
              if (crc_on) begin
                st_r <= CRC;
                bc_r <= `RPF_CRC_BITS;
                sh_r <= {crc_r ^ cw, 16'h0000};
              end else if (rx_r) begin
                end_rx;
              end else begin
                end_pkt;
              end
            end else if (rx_r || txf_valid_in) begin
              bc_r <= tail_go ? {3'h0, m} : `RPF_BYTE_BITS;
              if (tail_go) begin
                tail_r <= 1'b1;
              end
              if (!rx_r) begin
                sh_r <= {tb ^ wb, 24'h000000};
                crc_r <= crc8f(crc_r, tb);
                pn_r <= pnn;
                if (hdr_r) begin
                  vlen_r <= tlb;
                  hdr_r <= 1'b0;
                end else if (!tail_go) begin
                  cnt_r <= cnt_r + 8'h01;
                  any_r <= 1'b1;
                end
              end
            end
          end else if (!rx_r) begin
            tx_shift;
          end else if (rbit) begin
            sh_r <= {sh_r[30:0], rx_bit_in};
            bc_r <= bc_r - 6'h01;
            if (bc_r == 6'h01) begin
              rxf_valid_r <= 1'b1;
              rxf_data_r <= db;
              crc_r <= crc8f(crc_r, db);
              pn_r <= pnn;
              if (hdr_r) begin
                vlen_r <= lb;
                hdr_r <= 1'b0;
                if (lb > packet_length_reg_in) begin
                  drop;
                end
              end else begin
                if (adr_r) begin
                  adr_r <= 1'b0;
                  if (!amatch) begin
                    drop;
                  end
                end
                if (!tail_r) begin
                  cnt_r <= cnt_r + 8'h01;
                  any_r <= 1'b1;
                end
              end
            end
          end
        end
        CRC: begin
          if (!rx_r) begin
            if (bc_r == 6'h00) begin
              end_pkt;
            end else begin
              tx_shift;
            end
          end else if (rbit) begin
            sh_r <= {sh_r[30:0], rx_bit_in};
            bc_r <= bc_r - 6'h01;
            if (bc_r == 6'h01) begin
              ok_r <= ({sh_r[14:0], rx_bit_in} ^ cw) == crc_r;
              end_rx;
            end
          end
        end
        STAT: begin
          rxf_valid_r <= 1'b1;
          rxf_data_r <= bc_r == `RPF_STAT_BYTES ? rssi_in : {ok_r, link_quality_value_in};
          bc_r <= bc_r - 6'h01;
          if (bc_r == 6'h01) begin
            end_pkt;
          end
        end
        default: begin
          st_r <= IDLE;
        end
      endcase
    end
  end
endmodule

// *** common/rpf_regs.vh ***
/*
  Constants of the radio packet framer: preamble patterns, length and
  address modes, sync lengths, CRC and whitening seeds.
  Assumes inclusion by the framer module and the test bench.
*/
`ifndef RPF_REGS_VH
`define RPF_REGS_VH
`define RPF_PRE_1010 8'hAA
`define RPF_PRE_0101 8'h55
`define RPF_PRE_0011 8'h33
`define RPF_PRE_1100 8'hCC
`define RPF_LEN_FIXED 2'h0
`define RPF_LEN_VAR 2'h1
`define RPF_LEN_INF 2'h2
`define RPF_LEN_VAR5 2'h3
`define RPF_LEN5_MASK 8'h1F
`define RPF_ADDR_BC0FF 2'h3
`define RPF_BCAST_LO 8'h00
`define RPF_BCAST_HI 8'hFF
`define RPF_SYNC_11 3'h0
`define RPF_SYNC_16 3'h1
`define RPF_SYNC_18 3'h2
`define RPF_SYNC_24 3'h3
`define RPF_BITS_11 6'h0B
`define RPF_BITS_16 6'h10
`define RPF_BITS_18 6'h12
`define RPF_BITS_24 6'h18
`define RPF_BITS_32 6'h20
`define RPF_CRC_POLY 16'h8005
`define RPF_CRC_INIT 16'hFFFF
`define RPF_PN9_INIT 9'h1FF
`define RPF_CRC_BITS 6'h10
`define RPF_BYTE_BITS 6'h08
`define RPF_STAT_BYTES 6'h02
`endif

// *** testbench/rpf_framer_sva.sv ***
/* Port checker for rpf_framer.
   Assumes one clock, synchronous active-high reset, bound below. */
module rpf_framer_sva #(
  parameter PRE_W = 4
) (
  input wire clk_in,
  input wire srst_in,
  input wire tx_start_in,
  input wire stop_in,
  input wire [1:0] preamble_sel_in,
  input wire txf_valid_in,
  input wire txf_ready_out,
  input wire tx_bit_out,
  input wire tx_bit_valid_out,
  input wire tx_bit_ready_in,
  input wire busy_out,
  input wire exit_valid_out,
  input wire discard_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence s_launch;
    !busy_out && tx_start_in && !stop_in;
  endsequence
  sequence s_first_bit;
    !tx_bit_valid_out ##1 tx_bit_valid_out;
  endsequence
  a_start_taken: assert property (s_launch |=> busy_out) else $error("start ignored");
  a_first_bit: assert property (s_launch |=> s_first_bit) else $error("first bit late");
  a_pre_msb: assert property (s_launch |-> ##2 tx_bit_out == (preamble_sel_in[1] ~^ preamble_sel_in[0]))
    else $error("wrong preamble bit");
  a_bit_hold: assert property (tx_bit_valid_out && !tx_bit_ready_in && !stop_in |=>
    tx_bit_valid_out && $stable(tx_bit_out)) else $error("bit not held");
  a_pop_data: assert property (txf_ready_out |-> txf_valid_in ##1 !txf_ready_out) else $error("bad pop");
  a_idle_quiet: assert property (!busy_out |-> !tx_bit_valid_out && !txf_ready_out) else $error("idle activity");
  a_stop_idle: assert property (stop_in |=> !busy_out && !exit_valid_out) else $error("stop ignored");
  a_exit_pulse: assert property (exit_valid_out |-> !busy_out ##1 !exit_valid_out) else $error("bad exit");
  a_discard_hunt: assert property (discard_out && !stop_in |=> !discard_out && busy_out)
    else $error("bad discard");
endmodule

bind rpf_framer rpf_framer_sva #(.PRE_W(PRE_W)) u_sva (
  .clk_in, .srst_in, .tx_start_in, .stop_in, .preamble_sel_in, .txf_valid_in, .txf_ready_out,
  .tx_bit_out, .tx_bit_valid_out, .tx_bit_ready_in, .busy_out, .exit_valid_out, .discard_out
);

// *** testbench/rpf_modem_model.sv ***
/* Host transmit FIFO and modem bit sink.
   Assumes the bench fills fifo_q and reads bits_q by hierarchy. */
module rpf_modem_model (
  input wire clk_in,
  input wire slow_in,
  input wire pop_in,
  input wire bit_in,
  input wire bit_valid_in,
  output logic fifo_valid_out = 1'b0,
  output logic [7:0] fifo_data_out = 8'h00,
  output logic bit_ready_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fifo_q[$];
  logic bits_q[$];
  int n_pop = 0;
  logic ph = 1'b0;
  always @(posedge clk_in) begin
    if (pop_in === 1'b1 && fifo_q.size() > 0) begin
      void'(fifo_q.pop_front());
      n_pop++;
    end
    if (bit_valid_in === 1'b1 && bit_ready_out)
      bits_q.push_back(bit_in);
  end
  // Stall every other cycle when slow; empty FIFO shows changing data
  always @(negedge clk_in) begin
    ph <= ~ph;
    bit_ready_out <= !slow_in || ph;
    fifo_valid_out <= fifo_q.size() > 0;
    fifo_data_out <= fifo_q.size() > 0 ? fifo_q[0] : ~fifo_data_out;
  end
endmodule

// *** testbench/radio_packet_framer_test.sv ***
/* Self-checking bench for rpf_framer.
   Assumes rpf_modem_model and the bound port checker. */
`include "rpf_regs.vh"
module radio_packet_framer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, srst_in = 1'b1, tx_start_in = 1'b0, rx_start_in = 1'b0, stop_in = 1'b0, slow = 1'b1;
  logic crc_en_in = 1'b0, append_status_en_in = 1'b0, whitening_en_in = 1'b0, rx_bit_in = 1'b0, rx_bit_valid_in = 1'b0;
  logic [1:0] preamble_sel_in = 2'h0, addr_check_in = 2'h0, length_cfg_in = 2'h0;
  logic [1:0] tx_exit_state_in = 2'h2, rx_exit_state_in = 2'h1, ex_st = 2'h0;
  logic [2:0] sync_len_in = 3'h1, tail_bit_count_in = 3'h0;
  logic [3:0] preamble_min_in = 4'h2;
  logic [7:0] node_address_in = 8'h3C, packet_length_reg_in = 8'h03, rssi_in = 8'hC3;
  logic [6:0] link_quality_value_in = 7'h2B;
  logic [31:0] sync_word_bytes_in = 32'h5A0FD391;
  wire txf_valid_in, tx_bit_ready_in, txf_ready_out, tx_bit_out, tx_bit_valid_out, rxf_valid_out;
  wire busy_out, exit_valid_out, discard_out, crc_ok_out;
  wire [7:0] txf_data_in, rxf_data_out;
  wire [1:0] exit_state_out;
  logic [7:0] pre_tab[4] = '{8'hAA, 8'h55, 8'h33, 8'hCC};
  logic [7:0] rq[$];
  int sl[5] = '{11, 16, 18, 24, 32};
  int n_mismatch = 0, compares = 0, n_exit = 0, n_disc = 0, cyc = 0;
  rpf_framer #(.PRE_W(4)) u_dut (
    .clk_in, .srst_in, .tx_start_in, .rx_start_in, .stop_in, .preamble_sel_in, .preamble_min_in,
    .sync_word_bytes_in, .sync_len_in, .crc_en_in, .append_status_en_in, .whitening_en_in, .addr_check_in,
    .node_address_in, .length_cfg_in, .packet_length_reg_in, .tail_bit_count_in, .tx_exit_state_in,
    .rx_exit_state_in, .rssi_in, .link_quality_value_in, .txf_valid_in, .txf_data_in, .txf_ready_out,
    .tx_bit_out, .tx_bit_valid_out, .tx_bit_ready_in, .rx_bit_in, .rx_bit_valid_in, .rxf_valid_out,
    .rxf_data_out, .busy_out, .exit_valid_out, .exit_state_out, .discard_out, .crc_ok_out
  );
  rpf_modem_model u_model (
    .clk_in, .slow_in(slow), .pop_in(txf_ready_out), .bit_in(tx_bit_out), .bit_valid_in(tx_bit_valid_out),
    .fifo_valid_out(txf_valid_in), .fifo_data_out(txf_data_in), .bit_ready_out(tx_bit_ready_in)
  );
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (rxf_valid_out === 1'b1)
      rq.push_back(rxf_data_out);
    if (exit_valid_out === 1'b1) begin
      n_exit++;
      ex_st = exit_state_out;
    end
    if (discard_out === 1'b1)
      n_disc++;
    if (cyc == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Reference CRC over one byte, MSB first
  function automatic logic [15:0] crcf(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `RPF_CRC_POLY : 16'h0000);
    return c;
  endfunction
  function automatic logic [7:0] txb(input int pos);
    for (int i = 0; i < 8; i++)
      txb[7-i] = u_model.bits_q[pos+i];
  endfunction
  task automatic pulse(ref logic s);
    @(negedge clk_in) s = 1'b1;
    @(negedge clk_in) s = 1'b0;
  endtask
  task automatic push_q(input logic [7:0] q[$]);
    foreach (q[i])
      u_model.fifo_q.push_back(q[i]);
  endtask
  task automatic tx_run(input int nbits, input bit long_pkt);
    int e0, pre, sw;
    e0 = n_exit;
    pre = 8 * preamble_min_in;
    sw = sl[sync_len_in];
    u_model.bits_q.delete();
    u_model.n_pop = 0;
    pulse(tx_start_in);
    if (long_pkt) begin
      for (int i = 0; i < 4000 && u_model.n_pop < 3; i++) @(negedge clk_in);
      length_cfg_in = 2'h0;
    end
    for (int i = 0; i < 9000 && n_exit == e0; i++) @(negedge clk_in);
    check("bit count", nbits, u_model.bits_q.size());
    check("tx exit", tx_exit_state_in, ex_st);
    for (int i = 0; i < pre; i += 8) check("preamble", pre_tab[preamble_sel_in], txb(i));
    for (int i = 0; i < sw; i++) check("sync", sync_word_bytes_in[sw-1-i], u_model.bits_q[pre+i]);
  endtask
  task automatic rx_bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk_in) rx_bit_in = v[i];
      rx_bit_valid_in = 1'b1;
      @(negedge clk_in) rx_bit_valid_in = 1'b0;
      rx_bit_in = ~v[i];
      @(negedge clk_in);
    end
  endtask
  task automatic rx_head(input logic [7:0] b, input int n);
    rq.delete();
    pulse(rx_start_in);
    rx_bits(sync_word_bytes_in, sl[sync_len_in]);
    rx_bits(b, n);
  endtask
  initial begin
    int e0;
    repeat (16) @(negedge clk_in);
    srst_in = 1'b0;
    push_q('{8'hAB, 8'h80, 8'hFF});
    tx_run(16 + 16 + 24, 0);
    check("data", 8'hFF, txb(48));
    preamble_sel_in = 2'h1;
    preamble_min_in = 4'h3;
    sync_len_in = 3'h0;
    whitening_en_in = 1'b1;
    crc_en_in = 1'b1;
    packet_length_reg_in = 8'h02;
    slow = 1'b0;
    push_q('{8'hAB, 8'h80});
    tx_run(24 + 11 + 16 + 16, 0);
    check("white 0", 8'h54, txb(35));
    check("white 1", 8'h61, txb(43));
    check("tx crc", crcf(crcf(`RPF_CRC_INIT, 8'hAB), 8'h80) ^ 16'h1D9A, {txb(51), txb(59)});
    preamble_sel_in = 2'h2;
    preamble_min_in = 4'h1;
    sync_len_in = 3'h2;
    whitening_en_in = 1'b0;
    packet_length_reg_in = 8'h01;
    tail_bit_count_in = 3'h3;
    push_q('{8'h3C, 8'hA5});
    tx_run(8 + 18 + 8 + 3, 0);
    check("tail", 3'h5, {u_model.bits_q[34], u_model.bits_q[35], u_model.bits_q[36]});
    tail_bit_count_in = 3'h0;
    crc_en_in = 1'b0;
    packet_length_reg_in = 8'h10;
    preamble_sel_in = 2'h3;
    for (int k = 0; k < 2; k++) begin
      length_cfg_in = k ? 2'h3 : 2'h1;
      sync_len_in = k ? 3'h4 : 3'h3;
      push_q('{k ? 8'hE2 : 8'h02, 8'h11, 8'h22});
      tx_run(8 + sl[sync_len_in] + 24, 0);
    end
    length_cfg_in = 2'h2;
    packet_length_reg_in = 8'h02;
    sync_len_in = 3'h1;
    for (int i = 0; i < 258; i++)
      u_model.fifo_q.push_back(i[7:0]);
    tx_run(8 + 16 + 258 * 8, 1);
    check("last byte", 8'h01, txb(8 + 16 + 257 * 8));
    append_status_en_in = 1'b1;
    crc_en_in = 1'b1;
    length_cfg_in = 2'h0;
    // Good CRC, tail packet with CRC forced off, then a corrupted CRC
    for (int k = 0; k < 3; k++) begin
      packet_length_reg_in = k == 1 ? 8'h00 : 8'h01;
      tail_bit_count_in = k == 1 ? 3'h3 : 3'h0;
      e0 = n_exit;
      rx_head(k == 1 ? 8'h05 : 8'h5A, k == 1 ? 3 : 8);
      if (k != 1)
        rx_bits(crcf(`RPF_CRC_INIT, 8'h5A) ^ {15'h0000, k == 2}, 16);
      for (int i = 0; i < 200 && n_exit == e0; i++) @(negedge clk_in);
      check("rx data", k == 1 ? 8'hA0 : 8'h5A, rq[0]);
      check("rssi", rssi_in, rq[1]);
      check("crc lqi", {k != 2, link_quality_value_in}, rq[2]);
      check("crc ok", k != 2, crc_ok_out);
      check("rx exit", rx_exit_state_in, ex_st);
    end
    append_status_en_in = 1'b0;
    crc_en_in = 1'b0;
    tail_bit_count_in = 3'h0;
    length_cfg_in = 2'h1;
    packet_length_reg_in = 8'h01;
    for (int k = 0; k < 4; k++) begin
      addr_check_in = k[1:0];
      e0 = n_disc;
      rx_head(k ? 8'h01 : 8'h05, 8);
      rx_bits(8'hFF, 8);
      repeat (20) @(negedge clk_in);
      check("discard", k < 3, n_disc - e0);
      pulse(stop_in);
      check("stopped", 1'b0, busy_out);
    end
    finish_test();
  end
endmodule
